//--- verilog/rc_timing_pin_defines.svh
`ifndef RC_TIMING_DEFINES_SVH
`define RC_TIMING_DEFINES_SVH

// Counter width and terminal count
`define MEAS_CNT_W 16
`define MEAS_CNT_TERM 16'hffff
`define MEAS_CNT_RESET 16'h0000

// Counter-rate select codes, value is log2 of the divide ratio
`define MEAS_RATE_W 2
`define MEAS_RATE_48 2'h0
`define MEAS_RATE_24 2'h1
`define MEAS_RATE_12 2'h2
`define MEAS_RATE_6 2'h3
`define MEAS_DIV_W 3

// Glitch filter length in main clock cycles
`define MEAS_FILT_LEN 2'h3
`define MEAS_FILT_W 2

`endif

//--- verilog/measure_done_irq_pkg.sv
package rc_meas_pkg;

  typedef enum logic [4:0] {
    ST_RESET  = 5'h01,
    ST_ARMED  = 5'h02,
    ST_DISCH  = 5'h04,
    ST_CHARGE = 5'h08,
    ST_DONE   = 5'h10
  } phase_t;

endpackage

//--- verilog/rc_count_if.sv
`timescale 1ns/1ns
`include "rc_timing_pin_defines.svh"

interface rc_count_if;
  logic run;
  logic clear;
  logic [`MEAS_RATE_W-1:0] rate_sel;
  logic tick;
  logic wrap;
  logic [`MEAS_CNT_W-1:0] count;

  modport ctrl (output run, output clear, output rate_sel, input tick, input wrap, input count);
  modport counter (input run, input clear, input rate_sel, output tick, output wrap, output count);
endinterface

//--- verilog/rc_timebase.sv
`timescale 1ns/1ns
`include "rc_timing_pin_defines.svh"

module rc_timebase (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Counter control
  rc_count_if.counter cif
);

  logic [`MEAS_DIV_W-1:0] div_q;
  logic [`MEAS_DIV_W-1:0] div_d;
  logic [`MEAS_CNT_W-1:0] cnt_q;
  logic [`MEAS_CNT_W-1:0] cnt_d;

  // Last divider value before a tick for a given rate code
  function automatic logic [`MEAS_DIV_W-1:0] div_last(input logic [`MEAS_RATE_W-1:0] sel);
    div_last = (`MEAS_DIV_W'(1) << sel) - `MEAS_DIV_W'(1);
  endfunction

  // Tick is an enable, not a derived clock, so everything stays on mclk
  assign cif.tick = cif.run && (div_q == div_last(cif.rate_sel));
  assign cif.wrap = cif.tick && (cnt_q == `MEAS_CNT_TERM);
  assign cif.count = cnt_q;

  always_comb begin
    div_d = div_q;
    cnt_d = cnt_q;
    if (cif.clear) begin
      div_d = '0;
      cnt_d = `MEAS_CNT_RESET;
    end else if (cif.run) begin
      div_d = cif.tick ? '0 : div_q + `MEAS_DIV_W'(1);
      // Wrap past the terminal count restarts the next phase from zero
      if (cif.tick) begin
        cnt_d = cnt_q + `MEAS_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= '0;
      cnt_q <= `MEAS_CNT_RESET;
    end else begin
      div_q <= div_d;
      cnt_q <= cnt_d;
    end
  end

endmodule

//--- verilog/rc_timing_meas.sv
`timescale 1ns/1ns
`include "rc_timing_pin_defines.svh"

module rc_timing_meas
  import rc_meas_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Control bits from firmware
  input wire logic enable,
  input wire logic start,
  input wire logic [`MEAS_RATE_W-1:0] clock_set,
  // Status bits and result
  output logic discharge_complete,
  output logic measure_error,
  output logic measure_done,
  output logic [`MEAS_CNT_W-1:0] result,
  // Interrupt and power
  output logic measure_done_irq,
  output logic clock_req,
  // Pin: comparator output (high above threshold) and open-drain discharge
  input wire logic rc_timing_pin,
  output logic rc_timing_pin_out,
  output logic rc_timing_pin_oe
);

  rc_count_if cif ();

  rc_timebase u_timebase (
    .mclk(mclk),
    .rst_n(rst_n),
    .cif(cif)
  );

  phase_t state_q;
  phase_t state_d;
  logic sync1_q;
  logic sync2_q;
  logic filt_q;
  logic filt_d;
  logic [`MEAS_FILT_W-1:0] fcnt_q;
  logic [`MEAS_FILT_W-1:0] fcnt_d;
  logic tc_q;
  logic tc_d;
  logic err_q;
  logic err_d;
  logic done_q;
  logic done_d;
  logic irq_q;
  logic irq_d;
  logic creq_q;
  logic creq_d;
  logic oe_q;
  logic oe_d;
  logic [`MEAS_CNT_W-1:0] res_q;
  logic [`MEAS_CNT_W-1:0] res_d;

  // Comparator is asynchronous to mclk
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= rc_timing_pin;
      sync2_q <= sync1_q;
    end
  end

  // Glitch filter
  always_comb begin
    filt_d = filt_q;
    fcnt_d = '0;
    if (sync2_q != filt_q) begin
      fcnt_d = fcnt_q + `MEAS_FILT_W'(1);
      if (fcnt_d == `MEAS_FILT_LEN) begin
        filt_d = sync2_q;
        fcnt_d = '0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      filt_q <= 1'b0;
      fcnt_q <= '0;
    end else begin
      filt_q <= filt_d;
      fcnt_q <= fcnt_d;
    end
  end

  // Counter steering follows the registered phase
  assign cif.run = (state_q == ST_DISCH) || (state_q == ST_CHARGE);
  assign cif.clear = (state_q == ST_RESET) || (state_q == ST_ARMED);
  assign cif.rate_sel = clock_set;

  // Phase machine
  always_comb begin
    state_d = state_q;
    tc_d = tc_q;
    err_d = err_q;
    done_d = done_q;
    res_d = res_q;
    irq_d = 1'b0;
    if (!enable) begin
      // Result survives reset of the phase so the last reading stays readable
      state_d = ST_RESET;
      tc_d = 1'b0;
      err_d = 1'b0;
      done_d = 1'b0;
    end else begin
      unique case (state_q)
        ST_RESET: begin
          if (!start) begin
            state_d = ST_ARMED;
          end
        end
        ST_ARMED: begin
          // Settling time before start is firmware's to keep
          if (start) begin
            state_d = ST_DISCH;
          end
        end
        ST_DISCH: begin
          if (cif.wrap) begin
            tc_d = 1'b1;
            err_d = filt_q;
            state_d = ST_CHARGE;
          end
        end
        ST_CHARGE: begin
          if (filt_q) begin
            res_d = cif.count;
            state_d = ST_DONE;
            done_d = 1'b1;
            irq_d = 1'b1;
          end else if (cif.wrap) begin
            res_d = `MEAS_CNT_TERM;
            err_d = 1'b1;
            state_d = ST_DONE;
            done_d = 1'b1;
            irq_d = 1'b1;
          end
        end
        ST_DONE: begin
          state_d = ST_DONE;
        end
      endcase
    end
    // Clock request is high for exactly the Discharge and Charge phases of a measurement
    creq_d = (state_d == ST_DISCH) || (state_d == ST_CHARGE);
    oe_d = (state_d == ST_DISCH);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_RESET;
      tc_q <= 1'b0;
      err_q <= 1'b0;
      done_q <= 1'b0;
      irq_q <= 1'b0;
      creq_q <= 1'b0;
      oe_q <= 1'b0;
      res_q <= `MEAS_CNT_RESET;
    end else begin
      state_q <= state_d;
      tc_q <= tc_d;
      err_q <= err_d;
      done_q <= done_d;
      irq_q <= irq_d;
      creq_q <= creq_d;
      oe_q <= oe_d;
      res_q <= res_d;
    end
  end

  assign discharge_complete = tc_q;
  assign measure_error = err_q;
  assign measure_done = done_q;
  assign result = res_q;
  assign measure_done_irq = irq_q;
  assign clock_req = creq_q;
  assign rc_timing_pin_oe = oe_q;
  // Open-drain: only ever pulls low
  assign rc_timing_pin_out = 1'b0;

endmodule

//--- sim/rc_net_model.sv
`timescale 1ns/1ns
module rc_net_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Pin drive and rise time in cycles
  input wire logic pin_oe,
  input wire logic pin_out,
  input wire logic [15:0] rise_cycles,
  // Comparator, high above threshold
  output logic above
);
  logic [15:0] age_q;
  // Cap drains at once when pulled low, then recharges slowly
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) age_q <= 16'hffff;
    else if (pin_oe && !pin_out) age_q <= 16'h0000;
    else if (age_q != 16'hffff) age_q <= age_q + 16'h0001;
  end
  assign above = age_q >= rise_cycles;
endmodule

//--- sim/rc_timing_meas_assertions.sv
`timescale 1ns/1ns
`include "rc_timing_pin_defines.svh"
module rc_timing_meas_assertions (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic start,
  input wire logic measure_done,
  input wire logic discharge_complete,
  input wire logic measure_error,
  input wire logic [`MEAS_CNT_W-1:0] result,
  input wire logic measure_done_irq,
  input wire logic clock_req,
  input wire logic rc_timing_pin_out,
  input wire logic rc_timing_pin_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Two armed samples put the phase in Armed whatever the arm wait was
  sequence armed_then_start;
    (enable && !start)[*2] ##1 (enable && start);
  endsequence
  start_disch_a: assert property (armed_then_start |=> rc_timing_pin_oe) else $error("no discharge");
  pin_low_a: assert property (rc_timing_pin_oe |-> !rc_timing_pin_out && clock_req) else $error("bad pin drive");
  disable_clear_a: assert property (!enable |=> !(measure_done || discharge_complete || measure_error
    || clock_req || rc_timing_pin_oe)) else $error("not cleared");
  irq_rise_a: assert property ($rose(measure_done) |-> measure_done_irq) else $error("no irq");
  irq_pulse_a: assert property (measure_done_irq |-> measure_done ##1 !measure_done_irq) else $error("irq");
  done_state_a: assert property (measure_done |-> discharge_complete && !clock_req && !rc_timing_pin_oe)
    else $error("done state");
  done_hold_a: assert property (measure_done && enable |=> measure_done) else $error("done lost");
  result_hold_a: assert property (!$rose(measure_done) |-> $stable(result)) else $error("result moved");
  tc_end_a: assert property ($fell(rc_timing_pin_oe) && $past(enable) |-> discharge_complete)
    else $error("no complete");
endmodule
bind rc_timing_meas rc_timing_meas_assertions chk (.mclk(mclk), .rst_n(rst_n), .enable(enable), .start(start),
  .measure_done(measure_done), .discharge_complete(discharge_complete), .measure_error(measure_error),
  .result(result), .measure_done_irq(measure_done_irq), .clock_req(clock_req),
  .rc_timing_pin_out(rc_timing_pin_out), .rc_timing_pin_oe(rc_timing_pin_oe));

//--- sim/rc_delay_identification_test.sv
`timescale 1ns/1ns
module rc_delay_identification_test;
  logic mclk, rst_n, enable, start, pin, pout, poe, tc, err, done, irq, creq;
  logic [1:0] clock_set;
  logic [15:0] result, rise, lo;
  logic [15:0] exp_q[$];
  int bad_count = 0, n_compared = 0, cycles = 0;
  rc_timing_meas uut (.mclk(mclk), .rst_n(rst_n), .enable(enable), .start(start), .clock_set(clock_set),
    .discharge_complete(tc), .measure_error(err), .measure_done(done), .result(result),
    .measure_done_irq(irq), .clock_req(creq), .rc_timing_pin(pin), .rc_timing_pin_out(pout),
    .rc_timing_pin_oe(poe));
  rc_net_model net (.mclk(mclk), .rst_n(rst_n), .pin_oe(poe), .pin_out(pout), .rise_cycles(rise), .above(pin));
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (exp !== got) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic ctl(logic e, logic s, logic [1:0] r);
    @(posedge mclk);
    enable <= e;
    start <= s;
    clock_set <= r;
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    mclk = 0;
    forever #4 mclk = ~mclk;
  end
  // Sampled mid-cycle so registered outputs are settled
  always @(negedge mclk) begin
    cycles++;
    if (irq === 1'b1) begin
      if (exp_q.size() == 0) check("unexpected_irq", 16'h0000, 16'h0001);
      else begin
        lo = exp_q.pop_front();
        check("result", lo, result);
      end
    end
    if (cycles == 80000) begin
      bad_count++;
      wrap_up;
    end
  end
  initial begin
    rst_n = 0; enable = 0; start = 0; clock_set = 0; rise = 16'd100;
    void'($urandom(32'h774d));
    repeat (4) @(posedge mclk);
    rst_n <= 1;
    ctl(0, 1, 0);
    repeat (3) @(posedge mclk);
    #1 check("idle", 0, {done, tc, err, creq, poe});
    ctl(1, 0, 2'($urandom));
    repeat (8) @(posedge mclk);
    ctl(1, 1, clock_set);
    repeat (50) @(posedge mclk);
    #1 check("discharging", 16'h0003, {poe, creq});
    ctl(0, 0, 0);
    repeat (2) @(posedge mclk);
    #1 check("aborted", 0, {poe, creq, tc});
    rise = 16'($urandom_range(400, 20));
    ctl(1, 0, 0);
    // Settle wait kept short: the full 300 us would push the run past its cycle budget
    repeat (64) @(posedge mclk);
    ctl(1, 1, 0);
    while (!tc) @(posedge mclk);
    #1 check("disch_end", 0, {err, poe});
    // Capture lands five cycles after the rise: two sync stages, then three filter cycles
    exp_q.push_back(rise + 16'd5);
    while (!done) @(posedge mclk);
    repeat (20) @(posedge mclk);
    #1 check("done_hold", 16'h0004, {done, creq, err});
    ctl(0, 0, 0);
    repeat (2) @(posedge mclk);
    #1 check("cleared", 0, {done, tc, err});
    check("kept", rise + 16'd5, result);
    check("pending", 16'h0000, 16'(exp_q.size()));
    @(posedge mclk);
    rst_n <= 0;
    @(posedge mclk);
    #1 check("sys_reset", 0, result);
    wrap_up;
  end
endmodule
